// [core/bsid_top.sv]
`default_nettype none
module bsid_top
  import bsid_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic tck_i,
  input wire logic tdi_i,
  input wire bsid_tap_s tap_i,
  input wire logic [CHAIN_LEN-1:0] observe_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output bsid_status_s status_o,
  output logic [CHAIN_LEN-1:0] cell_drive_o,
  output logic [IR_W-1:0] instr_o,
  output logic [CTRL_W-1:0] control_o
);
  // ****************************************
  // pin sampling and test clock edges
  // ****************************************
  logic [1:0] link_s;
  logic tck_s;
  logic tdi_s;
  logic tck_q;
  logic rise;
  logic fall;
  logic [CHAIN_LEN-1:0] obs_s;

  bsid_sync #(.W(2)) u_link_sync (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .d_i({tck_i, tdi_i}),
    .q_o(link_s)
  );

  // pins can change at any time; sampled like the link
  bsid_sync #(.W(CHAIN_LEN)) u_obs_sync (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .d_i(observe_i),
    .q_o(obs_s)
  );

  assign tck_s = link_s[1];
  assign tdi_s = link_s[0];

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tck_q <= 1'b0;
    end else begin
      tck_q <= tck_s;
    end
  end

  assign rise = tck_s & ~tck_q;
  assign fall = ~tck_s & tck_q;

  // ****************************************
  // instruction chain
  // ****************************************
  logic [IR_W-1:0] ir_shift;
  logic [IR_W-1:0] ir;
  bsid_decode_s dec;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ir_shift <= IR_RESET;
    end else if (tap_i.test_reset) begin
      ir_shift <= IR_RESET;
    end else if (rise && tap_i.capture_ir) begin
      ir_shift <= IR_CAPTURE;
    end else if (rise && tap_i.shift_ir) begin
      ir_shift <= {tdi_s, ir_shift[IR_W-1:1]};
    end
  end

  // new instruction takes effect on the falling edge in Update-IR
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ir <= IR_RESET;
    end else if (tap_i.test_reset) begin
      ir <= IR_RESET;
    end else if (fall && tap_i.update_ir) begin
      ir <= ir_shift;
    end
  end

  assign dec = bsid_decode(ir);
  assign instr_o = ir;

  // ****************************************
  // bypass and control chains
  // ****************************************
  logic bypass;
  logic [CTRL_W-1:0] ctl_shift;
  logic [CTRL_W-1:0] ctl;
  logic sel_bypass;
  logic sel_chain;
  logic sel_ctl;

  assign sel_bypass = (dec.dr == DR_BYPASS);
  assign sel_chain = (dec.dr == DR_BOUNDARY);
  assign sel_ctl = (dec.dr == DR_CONTROL);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bypass <= 1'b0;
    end else if (rise && sel_bypass && tap_i.capture_dr) begin
      bypass <= 1'b0;
    end else if (rise && sel_bypass && tap_i.shift_dr) begin
      bypass <= tdi_s;
    end
  end

  // capture leaves the control chain alone
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_shift <= CTRL_RESET;
    end else if (tap_i.test_reset) begin
      ctl_shift <= CTRL_RESET;
    end else if (rise && sel_ctl && tap_i.shift_dr) begin
      ctl_shift <= {tdi_s, ctl_shift[CTRL_W-1:1]};
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl <= CTRL_RESET;
    end else if (tap_i.test_reset) begin
      ctl <= CTRL_RESET;
    end else if (fall && sel_ctl && tap_i.update_dr) begin
      ctl <= ctl_shift;
    end
  end

  assign control_o = ctl;

  // ****************************************
  // run-test selection
  // ****************************************
  logic [CHAIN_LEN-1:0] chain_sh;
  logic [CHAIN_LEN-1:0] chain_shadow;
  logic a_to_b;
  logic b_to_a;
  logic [CTRL_OP_W-1:0] ctl_op;
  logic run_sample_toggle;
  logic run_toggle_only;
  logic [CHAIN_LEN-1:0] sel_in;
  logic [CHAIN_LEN-1:0] sel_out;

  // both enables set means A to B, neither means B to A; exactly one set means no run
  assign a_to_b = chain_shadow[OE_AB_BIT] & chain_shadow[OE_BA_BIT];
  assign b_to_a = ~chain_shadow[OE_AB_BIT] & ~chain_shadow[OE_BA_BIT];
  assign ctl_op = ctl[CTRL_OP_LO +: CTRL_OP_W];

  // signature, pattern and count runs are not built here; they hold
  assign run_sample_toggle = (ir == OPC_RUN_SELECTED_TEST) &&
    (ctl_op[1:0] == OP_SAMPLE_TOGGLE) && tap_i.run_idle;
  assign run_toggle_only = (ir == OPC_OUTPUT_TOGGLE_INSTR) &&
    tap_i.run_idle;

  always_comb begin
    sel_in = '0;
    sel_out = '0;
    if (a_to_b) begin
      sel_in[A_IN_LO +: PORT_W] = '1;
      sel_out[B_OUT_LO +: PORT_W] = '1;
    end else if (b_to_a) begin
      sel_in[B_IN_LO +: PORT_W] = '1;
      sel_out[A_OUT_LO +: PORT_W] = '1;
    end
  end

  // ****************************************
  // boundary chain
  // ****************************************
  logic [CHAIN_LEN-1:0] cell_load;
  logic [CHAIN_LEN-1:0] cell_val;
  logic [CHAIN_LEN-1:0] cell_upd;
  logic [CHAIN_LEN-1:0] chain_in;

  assign chain_in = {tdi_s, chain_sh[CHAIN_LEN-1:1]};

  always_comb begin
    cell_load = '0;
    cell_val = '0;
    cell_upd = '0;
    for (int i = 0; i < CHAIN_LEN; i++) begin
      if (sel_chain && tap_i.capture_dr) begin
        cell_load[i] = rise;
        unique case (dec.cap)
          CAP_PINS: cell_val[i] = obs_s[i];
          CAP_INVERT: cell_val[i] = ~chain_shadow[i];
          default: cell_val[i] = chain_sh[i];
        endcase
      end else if (sel_chain && tap_i.shift_dr) begin
        cell_load[i] = rise;
        cell_val[i] = chain_in[i];
      end else if (run_sample_toggle && sel_in[i]) begin
        cell_load[i] = rise;
        cell_val[i] = obs_s[i];
        cell_upd[i] = fall;
      end else if ((run_sample_toggle || run_toggle_only) && sel_out[i]) begin
        cell_load[i] = rise;
        cell_val[i] = ~chain_sh[i];
        cell_upd[i] = fall;
      end
      // input cells are left untouched by the toggle instruction
      if (sel_chain && tap_i.update_dr) begin
        cell_upd[i] = fall;
      end
    end
  end

  for (genvar g = 0; g < CHAIN_LEN; g++) begin : g_cell
    bsid_cell #(.RST_VAL(CHAIN_RESET[g])) u_cell (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .clear_i(tap_i.test_reset),
      .load_i(cell_load[g]),
      .load_val_i(cell_val[g]),
      .update_i(cell_upd[g]),
      .shift_o(chain_sh[g]),
      .shadow_o(chain_shadow[g])
    );
  end

  // shadows feed core inputs and output pins while in test mode
  assign cell_drive_o = chain_shadow;

  // ****************************************
  // mode and status
  // ****************************************
  bsid_status_s status;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status <= '0;
    end else begin
      status.test_mode <= (dec.mode == MODE_TEST);
      status.highz <= (dec.mode == MODE_HIGHZ);
      status.bypass_sel <= sel_bypass;
      status.boundary_sel <= sel_chain;
      status.control_sel <= sel_ctl;
    end
  end

  assign status_o = status;

  // ****************************************
  // serial output
  // ****************************************
  logic dr_lsb;

  always_comb begin
    unique case (dec.dr)
      DR_BOUNDARY: dr_lsb = chain_sh[0];
      DR_CONTROL: dr_lsb = ctl_shift[0];
      default: dr_lsb = bypass;
    endcase
  end

  // serial output changes on the falling edge only
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (fall) begin
      tdo_oe_o <= tap_i.shift_ir | tap_i.shift_dr;
      tdo_o <= tap_i.shift_ir ? ir_shift[0] : dr_lsb;
    end
  end
endmodule
`default_nettype wire

// [core/bsid_pkg.sv]
`default_nettype none
package bsid_pkg;
  // ****************************************
  // sizes and reset values
  // ****************************************
  localparam int IR_W = 8;
  localparam int CHAIN_LEN = 38;
  localparam int CTRL_W = 11;
  localparam logic [7:0] IR_CAPTURE = 8'h81;
  localparam logic [7:0] IR_RESET = 8'hFF;
  localparam logic [10:0] CTRL_RESET = 11'h002;
  localparam logic [37:0] CHAIN_RESET = 38'h10_0000_0000;
  // ****************************************
  // boundary chain layout
  // ****************************************
  localparam int OE_AB_BIT = 37;
  localparam int OE_BA_BIT = 36;
  localparam int CTRL_LO = 32;
  localparam int A_IN_LO = 24;
  localparam int A_OUT_LO = 16;
  localparam int B_IN_LO = 8;
  localparam int B_OUT_LO = 0;
  localparam int PORT_W = 8;
  localparam int CTRL_OP_LO = 0;
  localparam int CTRL_OP_W = 3;
  localparam int CTRL_MASK_LO = 3;
  localparam logic [1:0] OP_SAMPLE_TOGGLE = 2'h0;
  // ****************************************
  // instruction opcodes
  // ****************************************
  localparam logic [7:0] OPC_BOUNDARY_EXT = 8'h00;
  localparam logic [7:0] OPC_SAMPLE = 8'h82;
  localparam logic [7:0] OPC_BOUNDARY_INT = 8'h03;
  localparam logic [7:0] OPC_HIGHZ = 8'h06;
  localparam logic [7:0] OPC_CLAMP = 8'h87;
  localparam logic [7:0] OPC_RUN_SELECTED_TEST = 8'h09;
  localparam logic [7:0] OPC_READ_BOUNDARY_NORMAL = 8'h0A;
  localparam logic [7:0] OPC_READ_BOUNDARY_TESTMODE = 8'h8B;
  localparam logic [7:0] OPC_CELL_SELF_CHECK = 8'h0C;
  localparam logic [7:0] OPC_OUTPUT_TOGGLE_INSTR = 8'h8D;
  localparam logic [7:0] OPC_CONTROL_SCAN_NORMAL = 8'h8E;
  localparam logic [7:0] OPC_CONTROL_SCAN_TESTMODE = 8'h0F;

  typedef enum logic [1:0] {DR_BYPASS, DR_BOUNDARY, DR_CONTROL} bsid_dr_e;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_TEST, MODE_HIGHZ} bsid_mode_e;
  typedef enum logic [1:0] {CAP_ZERO, CAP_PINS, CAP_KEEP, CAP_INVERT}
    bsid_cap_e;

  typedef struct packed {
    bsid_dr_e dr;
    bsid_mode_e mode;
    bsid_cap_e cap;
  } bsid_decode_s;

  // one-hot view of the tap controller state
  typedef struct packed {
    logic test_reset;
    logic run_idle;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;
  } bsid_tap_s;

  typedef struct packed {
    logic test_mode;
    logic highz;
    logic bypass_sel;
    logic boundary_sel;
    logic control_sel;
  } bsid_status_s;

  function automatic bsid_decode_s bsid_decode(input logic [7:0] opc);
    bsid_decode_s d;
    d = '{DR_BYPASS, MODE_NORMAL, CAP_ZERO};
    unique case (opc)
      OPC_BOUNDARY_EXT, OPC_BOUNDARY_INT:
        d = '{DR_BOUNDARY, MODE_TEST, CAP_PINS};
      OPC_SAMPLE: d = '{DR_BOUNDARY, MODE_NORMAL, CAP_PINS};
      OPC_HIGHZ: d = '{DR_BYPASS, MODE_HIGHZ, CAP_ZERO};
      OPC_CLAMP, OPC_RUN_SELECTED_TEST, OPC_OUTPUT_TOGGLE_INSTR:
        d = '{DR_BYPASS, MODE_TEST, CAP_ZERO};
      OPC_READ_BOUNDARY_NORMAL: d = '{DR_BOUNDARY, MODE_NORMAL, CAP_KEEP};
      OPC_READ_BOUNDARY_TESTMODE: d = '{DR_BOUNDARY, MODE_TEST, CAP_KEEP};
      OPC_CELL_SELF_CHECK: d = '{DR_BOUNDARY, MODE_NORMAL, CAP_INVERT};
      OPC_CONTROL_SCAN_NORMAL: d = '{DR_CONTROL, MODE_NORMAL, CAP_KEEP};
      OPC_CONTROL_SCAN_TESTMODE: d = '{DR_CONTROL, MODE_TEST, CAP_KEEP};
      default: d = '{DR_BYPASS, MODE_NORMAL, CAP_ZERO};
    endcase
    return d;
  endfunction
endpackage
`default_nettype wire

// [core/bsid_sync.sv]
`default_nettype none
module bsid_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
`default_nettype wire

// [core/bsid_cell.sv]
`default_nettype none
// one scan stage with its shadow latch
module bsid_cell #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic load_val_i,
  input wire logic update_i,
  output logic shift_o,
  output logic shadow_o
);
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shift_o <= RST_VAL;
    end else if (clear_i) begin
      shift_o <= RST_VAL;
    end else if (load_i) begin
      shift_o <= load_val_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shadow_o <= RST_VAL;
    end else if (clear_i) begin
      shadow_o <= RST_VAL;
    end else if (update_i) begin
      shadow_o <= shift_o;
    end
  end
endmodule
`default_nettype wire

// [test/bsid_monitor.sv]
`default_nettype none
module bsid_monitor
  import bsid_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic tck_i,
  input wire logic tdi_i,
  input wire bsid_tap_s tap_i,
  input wire logic [CHAIN_LEN-1:0] observe_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  input wire bsid_status_s status_o,
  input wire logic [CHAIN_LEN-1:0] cell_drive_o,
  input wire logic [IR_W-1:0] instr_o,
  input wire logic [CTRL_W-1:0] control_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  boundary_test_a: assert property (
    instr_o inside {8'h00, 8'h03} |=> status_o == 5'h12)
    else $error("boundary test decode wrong");
  sample_decode_a: assert property (
    instr_o == 8'h82 |=> status_o == 5'h02)
    else $error("sample decode wrong");
  parity_bypass_a: assert property (
    ^instr_o |=> status_o == 5'h04)
    else $error("odd parity opcode not bypass");
  highz_decode_a: assert property (
    instr_o == 8'h06 |=> status_o == 5'h0C)
    else $error("float decode wrong");
  test_bypass_a: assert property (
    instr_o inside {8'h87, 8'h09, 8'h8D} |=> status_o == 5'h14)
    else $error("test bypass decode wrong");
  control_decode_a: assert property (
    instr_o inside {8'h8E, 8'h0F} |=> status_o.control_sel &&
    status_o.test_mode != $past(instr_o[7]))
    else $error("control scan decode wrong");
  ir_hold_a: assert property (
    $changed(instr_o) |-> $past(tap_i.update_ir || tap_i.test_reset))
    else $error("instruction changed outside update");
  cell_hold_a: assert property (
    $changed(cell_drive_o) |-> $past(tap_i.test_reset ||
    tap_i.run_idle || tap_i.update_dr && status_o.boundary_sel))
    else $error("cell shadow changed outside update");
  tlr_clear_a: assert property (
    tap_i.test_reset |=> instr_o == 8'hFF && control_o == 11'h002 &&
    cell_drive_o == CHAIN_RESET)
    else $error("test reset did not clear");
  toggle_run_c: cover property (instr_o == 8'h8D && tap_i.run_idle);
  ctl_load_c: cover property ($changed(control_o));
  tlr_c: cover property (tap_i.test_reset);
endmodule
`default_nettype wire

// [test/bsid_ctl_model.sv]
`default_nettype none
module bsid_ctl_model
  import bsid_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic tdo_i,
  input wire logic tdo_oe_i,
  output logic tck_o,
  output logic tdi_o,
  output bsid_tap_s tap_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic oe_ok;
  initial begin
    tck_o = 1'b1;
    tdi_o = 1'b0;
    tap_o = '0;
    oe_ok = 1'b1;
  end
  // one state per test clock: fall then rise, state held well past both
  task automatic step(input bsid_tap_s s, input logic d, output logic q);
    @(posedge ref_clk_i);
    #1;
    tap_o = s;
    tdi_o = d;
    repeat (5) @(posedge ref_clk_i);
    #1 tck_o = 1'b0;
    repeat (10) @(posedge ref_clk_i);
    #1;
    q = tdo_i;
    oe_ok = oe_ok && (tdo_oe_i == (s.shift_ir || s.shift_dr));
    tck_o = 1'b1;
    // 10 clocks high and 10 low: an 80 ns test clock
    repeat (4) @(posedge ref_clk_i);
  endtask
  task automatic scan(input logic ir, input logic [37:0] d, input int n,
                      output logic [37:0] q);
    bsid_tap_s s;
    logic b;
    q = '0;
    s = '0;
    s.capture_ir = ir;
    s.capture_dr = !ir;
    step(s, tdi_o, b);
    s = '0;
    s.shift_ir = ir;
    s.shift_dr = !ir;
    for (int i = 0; i < n; i++) begin
      step(s, d[i], b);
      q[i] = b;
    end
    s = '0;
    s.update_ir = ir;
    s.update_dr = !ir;
    // data line no longer sampled: show the inverse, not a stale bit
    step(s, !d[n-1], b);
    step('0, !d[n-1], b);
  endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
`default_nettype none
module tb_top
  import bsid_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic tck, tdi, tdo, tdo_oe, b;
  bsid_tap_s tap;
  bsid_status_s status;
  logic [37:0] obs = '0;
  logic [37:0] cells, q;
  logic [7:0] instr;
  logic [10:0] ctrl;
  int n_errors = 0;
  int check_count = 0;
  localparam logic [37:0] D1 = 38'h31_A5C3_0F96;
  localparam logic [37:0] D2 = 38'h0E_5A3C_F069;
  localparam bsid_tap_s IDLE = 8'h40;
  localparam bsid_tap_s TLR = 8'h80;
  always #2 ref_clk_i = ~ref_clk_i;
  bsid_top bsid_top_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .tck_i(tck), .tdi_i(tdi), .tap_i(tap), .observe_i(obs), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .status_o(status), .cell_drive_o(cells),
    .instr_o(instr), .control_o(ctrl));
  bsid_ctl_model bsid_ctl_model_i (.ref_clk_i(ref_clk_i), .tdo_i(tdo),
    .tdo_oe_i(tdo_oe), .tck_o(tck), .tdi_o(tdi), .tap_o(tap));
  task automatic chk(input logic [37:0] got, input logic [37:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic set_obs(input logic [37:0] v);
    @(posedge ref_clk_i);
    #1 obs = v;
  endtask
  task automatic ir(input logic [7:0] o);
    bsid_ctl_model_i.scan(1'b1, {30'h0, o}, 8, q);
    chk(q[7:0], 8'h81);
  endtask
  task automatic dr(input logic [37:0] d);
    bsid_ctl_model_i.scan(1'b0, d, 38, q);
  endtask
  task automatic t_resetvals();
    chk(instr, 8'hFF);
    chk(ctrl, 11'h002);
    chk(cells, 38'h10_0000_0000);
    chk(status, 5'h04);
  endtask
  task automatic t_decode();
    logic [12:0] tab [17] = '{
      {8'h00, 5'h12}, {8'h03, 5'h12}, {8'h82, 5'h02}, {8'h84, 5'h04},
      {8'h05, 5'h04}, {8'h88, 5'h04}, {8'h80, 5'h04}, {8'h06, 5'h0C},
      {8'h87, 5'h14}, {8'h09, 5'h14}, {8'h8D, 5'h14}, {8'h0A, 5'h02},
      {8'h8B, 5'h12}, {8'h0C, 5'h02}, {8'h8E, 5'h01}, {8'h0F, 5'h11},
      {8'hFF, 5'h04}};
    foreach (tab[i]) begin
      ir(tab[i][12:5]);
      chk(status, tab[i][4:0]);
      if (tab[i][2]) begin
        bsid_ctl_model_i.scan(1'b0, 38'h1, 1, q);
        chk(q[0], 1'b0);
      end
    end
  endtask
  task automatic t_boundary();
    set_obs(D2);
    ir(8'h00);
    dr(~D1);
    chk(q, D2);
    chk(cells, ~D1);
    set_obs(~D2);
    ir(8'h82);
    dr(D1);
    chk(q, ~D2);
    chk(cells, D1);
  endtask
  task automatic t_read();
    ir(8'h0A);
    dr(D2);
    chk(q, D1);
    ir(8'h8B);
    dr(D1);
    chk(q, D2);
    ir(8'h0C);
    dr(D1);
    chk(q, ~D1);
    chk(cells, D1);
  endtask
  task automatic t_control();
    ir(8'h8E);
    bsid_ctl_model_i.scan(1'b0, 38'h5A8, 11, q);
    chk(q[10:0], 11'h002);
    chk(ctrl, 11'h5A8);
    ir(8'h0F);
    bsid_ctl_model_i.scan(1'b0, 38'h3A8, 11, q);
    chk(q[10:0], 11'h5A8);
    chk(ctrl, 11'h3A8);
  endtask
  task automatic t_run();
    ir(8'h8D);
    set_obs(D2);
    repeat (2) bsid_ctl_model_i.step(IDLE, 1'b0, b);
    chk(cells, {D1[37:8], ~D1[7:0]});
    // sample/toggle op already in the control chain
    ir(8'h09);
    repeat (2) bsid_ctl_model_i.step(IDLE, 1'b0, b);
    chk(cells, {D1[37:32], D2[31:24], D1[23:8], ~D1[7:0]});
  endtask
  initial begin
    #200us;
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge ref_clk_i);
    #1 resetn_i = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    t_resetvals();
    t_decode();
    t_boundary();
    t_read();
    t_control();
    t_run();
    bsid_ctl_model_i.step(TLR, 1'b0, b);
    t_resetvals();
    chk(bsid_ctl_model_i.oe_ok, 1'b1);
    give_verdict();
  end
endmodule
bind bsid_top bsid_monitor bsid_monitor_i (.ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i), .tck_i(tck_i), .tdi_i(tdi_i), .tap_i(tap_i),
  .observe_i(observe_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
  .status_o(status_o), .cell_drive_o(cell_drive_o), .instr_o(instr_o),
  .control_o(control_o));
`default_nettype wire
